// File: hw/ief_host.sv
// core-side controller: ahb-lite registers driving the interrupt logic
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ief_host
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset,
  // ahb-lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic                         hready,
  input  wire logic [31:0]                  hwdata,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic                              irq,
  // event sources
  input  wire logic                         timer_zero_overflow,
  input  wire logic                         external_edge_pin,
  input  wire logic [ief_pkg::IEF_PINS-1:0] upper_port_b_pins,
  input  wire logic [ief_pkg::IEF_DW-1:0]   per_event,
  // link to the device
  ief_if.host                               link
);
  import ief_pkg::*;

  // ==========================================================
  // state
  logic [31:0]         hrdata_reg;
  logic                hready_reg;
  logic                ph_act_reg;
  logic                ph_write_reg;
  logic [4:0]          ph_addr_reg;
  ief_acc_state_t      acc_state;
  logic [IEF_AW-1:0]   addr_reg;
  logic [IEF_DW-1:0]   wdata_reg;
  logic                wr_reg;
  logic                rd_reg;
  logic [IEF_DW-1:0]   rd_result_reg;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic                irq_reg;
  logic                req_prev_reg;
  logic                t0_reg;
  logic                ext_reg;
  logic [IEF_PINS-1:0] pins_reg;
  logic [IEF_DW-1:0]   per_reg;

  logic accept;
  logic cmd_wr;
  logic stat_rd;
  logic [IRQ_W-1:0] irq_set;

  // hsize is not checked: only whole words are used
  assign accept = hsel && hready && htrans[1];
  assign cmd_wr = ph_act_reg && ph_write_reg && (ph_addr_reg == HOST_CMD_OFS);
  assign stat_rd = ph_act_reg && !ph_write_reg && (ph_addr_reg == HOST_IRQ_STAT_OFS);

  // ==========================================================
  // ahb slave: one wait state so that hrdata comes from a flop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ph_act_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= '0;
      hready_reg <= 1'b1;
    end else if (accept) begin
      ph_act_reg <= 1'b1;
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr[4:0];
      hready_reg <= 1'b0;
    end else if (ph_act_reg) begin
      ph_act_reg <= 1'b0;
      hready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hrdata_reg <= '0;
    end else if (ph_act_reg && !ph_write_reg) begin
      unique case (ph_addr_reg)
        HOST_CMD_OFS: begin
          hrdata_reg <= {15'h0000, wr_reg, addr_reg, wdata_reg};
        end
        HOST_STAT_OFS: begin
          hrdata_reg <= {16'h0000, rd_result_reg, 6'h00,
                         link.core_irq, acc_state == IEF_ACC_BUSY};
        end
        HOST_IRQ_STAT_OFS: begin
          hrdata_reg <= {30'h00000000, irq_stat_reg};
        end
        HOST_IRQ_MASK_OFS: begin
          hrdata_reg <= {30'h00000000, irq_mask_reg};
        end
        default: begin
          hrdata_reg <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // device access sequencer; commands while busy are dropped
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_state <= IEF_ACC_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rd_result_reg <= '0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      unique case (acc_state)
        IEF_ACC_IDLE: begin
          if (cmd_wr) begin
            addr_reg <= hwdata[15:8];
            wdata_reg <= hwdata[7:0];
            wr_reg <= hwdata[CMD_WRITE_BIT];
            rd_reg <= !hwdata[CMD_WRITE_BIT];
            acc_state <= IEF_ACC_BUSY;
          end
        end
        IEF_ACC_BUSY: begin
          if (link.reg_ack) begin
            rd_result_reg <= link.reg_rdata;
            acc_state <= IEF_ACC_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // interrupt status, read clears, set wins
  assign irq_set[IRQ_DONE_BIT] = (acc_state == IEF_ACC_BUSY) && link.reg_ack;
  assign irq_set[IRQ_REQ_BIT] = link.core_irq && !req_prev_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_prev_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      req_prev_reg <= link.core_irq;
      irq_stat_reg <= (stat_rd ? '0 : irq_stat_reg) | irq_set;
      if (ph_act_reg && ph_write_reg && (ph_addr_reg == HOST_IRQ_MASK_OFS)) begin
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // event sources pass through one flop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      t0_reg <= 1'b0;
      ext_reg <= 1'b0;
      pins_reg <= '0;
      per_reg <= '0;
    end else begin
      t0_reg <= timer_zero_overflow;
      ext_reg <= external_edge_pin;
      pins_reg <= upper_port_b_pins;
      per_reg <= per_event;
    end
  end

  // ==========================================================
  // outputs
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;
  assign irq = irq_reg;
  assign link.reg_addr = addr_reg;
  assign link.reg_wdata = wdata_reg;
  assign link.reg_wr = wr_reg;
  assign link.reg_rd = rd_reg;
  assign link.timer_zero_overflow = t0_reg;
  assign link.external_edge_pin = ext_reg;
  assign link.upper_port_b_pins = pins_reg;
  assign link.per_event = per_reg;

endmodule : ief_host
`default_nettype wire

// File: hw/ief_pkg.sv
// shared constants and types of the interrupt enable and flag logic
package ief_pkg;

  // ==========================================================
  // widths
  localparam int IEF_DW = 8;
  localparam int IEF_AW = 8;
  localparam int IEF_PINS = 4;

  // ==========================================================
  // device register addresses
  localparam logic [7:0] CORE_CTRL_ADDR = 8'h10;
  localparam logic [7:0] PER_EN_ADDR = 8'h8c;
  localparam logic [7:0] PER_FLAG_ADDR = 8'h0c;

  // ==========================================================
  // core control field positions
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int T0IE_BIT = 5;
  localparam int EXTIE_BIT = 4;
  localparam int PORT_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int T0IF_BIT = 2;
  localparam int EXTIF_BIT = 1;
  localparam int PORT_CHANGE_IRQ_FLAG_BIT = 0;

  // ==========================================================
  // peripheral field positions, shared by enables and flags
  localparam int ADC_BIT = 6;
  localparam int SSP_BIT = 3;
  localparam int CCP_BIT = 2;
  localparam int TIMER_TWO_COUNTER_BIT = 1;
  localparam int TIMER_ONE_COUNTER_BIT = 0;
  localparam logic [7:0] PER_IMPL_MASK = 8'h4f;

  // ==========================================================
  // values after reset
  localparam logic [7:0] CORE_CTRL_RESET = 8'h00;
  localparam logic [7:0] PER_EN_RESET = 8'h00;
  localparam logic [7:0] PER_FLAG_RESET = 8'h00;

  // ==========================================================
  // controller register offsets on the ahb side
  localparam logic [4:0] HOST_CMD_OFS = 5'h00;
  localparam logic [4:0] HOST_STAT_OFS = 5'h04;
  localparam logic [4:0] HOST_IRQ_STAT_OFS = 5'h08;
  localparam logic [4:0] HOST_IRQ_MASK_OFS = 5'h0c;
  localparam int CMD_WRITE_BIT = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REQ_BIT = 1;
  localparam int IRQ_W = 2;

  // ==========================================================
  // controller access sequencer
  typedef enum logic {
    IEF_ACC_IDLE,
    IEF_ACC_BUSY
  } ief_acc_state_t;

endpackage : ief_pkg

// File: hw/ief_if.sv
// link between the interrupt logic and its core side
`timescale 1ns/1ps
`default_nettype none
interface ief_if;
  import ief_pkg::*;

  // register access from the core side
  logic [IEF_AW-1:0]   reg_addr;
  logic [IEF_DW-1:0]   reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [IEF_DW-1:0]   reg_rdata;
  logic                reg_ack;
  // event sources
  logic                timer_zero_overflow;
  logic                external_edge_pin;
  logic [IEF_PINS-1:0] upper_port_b_pins;
  logic [IEF_DW-1:0]   per_event;
  // request to the core
  logic                core_irq;

  modport dev (
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    input  timer_zero_overflow, external_edge_pin,
    input  upper_port_b_pins, per_event,
    output reg_rdata, reg_ack, core_irq
  );

  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    output timer_zero_overflow, external_edge_pin,
    output upper_port_b_pins, per_event,
    input  reg_rdata, reg_ack, core_irq
  );

endinterface : ief_if
`default_nettype wire

// File: hw/ief_device.sv
// interrupt enable and flag logic, device end
// Operation
// - global enable bit 7 gates all requests
// - peripheral group enable gates peripheral requests
// - software sets group enable before peripheral requests
// - timer zero enable masks its overflow
// - external pin enable masks edge request
// - port change enable masks change request
// - timer zero overflow sets flag, software clears
// - external edge sets flag, software clears
// - any upper pin change sets flag
// - one peripheral enable per source position
// - timer one enable at bit zero
// - bits 7,5,4 read zero, ignore writes
// - peripheral flags at 0x0c, software cleared
`timescale 1ns/1ps
`default_nettype none
module ief_device
  import ief_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // link to the core side
  ief_if.dev                         link,
  // register views
  output logic [ief_pkg::IEF_DW-1:0] core_ctrl_view,
  output logic [ief_pkg::IEF_DW-1:0] per_en_view,
  output logic [ief_pkg::IEF_DW-1:0] per_flag_view
);
  import ief_pkg::*;

  // ==========================================================
  // state
  logic [IEF_DW-1:0]   core_reg;
  logic [IEF_DW-1:0]   core_next;
  logic [IEF_DW-1:0]   per_en_reg;
  logic [IEF_DW-1:0]   per_flag_reg;
  logic [IEF_DW-1:0]   rdata_reg;
  logic                ack_reg;
  logic                irq_reg;
  logic [IEF_PINS-1:0] pins_prev_reg;
  logic                edge_prev_reg;
  logic                primed_reg;

  // ==========================================================
  // decode
  logic wr_core;
  logic wr_en;
  logic wr_flag;
  logic set_t0;
  logic set_ext;
  logic set_rb;
  logic core_active;
  logic per_active;
  logic irq_next;

  assign wr_core = link.reg_wr && (link.reg_addr == CORE_CTRL_ADDR);
  assign wr_en = link.reg_wr && (link.reg_addr == PER_EN_ADDR);
  assign wr_flag = link.reg_wr && (link.reg_addr == PER_FLAG_ADDR);

  // ==========================================================
  // event detection
  // primed blocks a false change right after reset, when the
  // previous-sample registers hold zero, not the pin levels
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pins_prev_reg <= '0;
      edge_prev_reg <= 1'b0;
    end else begin
      pins_prev_reg <= link.upper_port_b_pins;
      edge_prev_reg <= link.external_edge_pin;
    end
  end

  assign set_t0 = link.timer_zero_overflow;
  // rising edge only; a falling edge is not an event
  assign set_ext = primed_reg && link.external_edge_pin && !edge_prev_reg;
  assign set_rb = primed_reg && (link.upper_port_b_pins != pins_prev_reg);

  // ==========================================================
  // core control register
  always_comb begin
    core_next = core_reg;
    if (wr_core) begin
      core_next = link.reg_wdata;
    end
    // a whole-byte write loads the flags too, so software may set them
    // set wins over a clearing write in the same cycle
    if (set_t0) begin
      core_next[T0IF_BIT] = 1'b1;
    end
    if (set_ext) begin
      core_next[EXTIF_BIT] = 1'b1;
    end
    if (set_rb) begin
      core_next[PORT_CHANGE_IRQ_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      core_reg <= CORE_CTRL_RESET;
    end else begin
      core_reg <= core_next;
    end
  end

  // ==========================================================
  // peripheral enables
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      per_en_reg <= PER_EN_RESET;
    end else if (wr_en) begin
      per_en_reg <= link.reg_wdata & PER_IMPL_MASK;
    end
  end

  // ==========================================================
  // peripheral flags, one slice per position
  genvar gi;
  generate
    for (gi = 0; gi < IEF_DW; gi++) begin : g_flag
      if (PER_IMPL_MASK[gi]) begin : g_impl
        always_ff @(posedge clock or posedge reset) begin
          if (reset) begin
            per_flag_reg[gi] <= PER_FLAG_RESET[gi];
          // an event beats a clearing write in the same cycle
          end else if (link.per_event[gi]) begin
            per_flag_reg[gi] <= 1'b1;
          end else if (wr_flag) begin
            per_flag_reg[gi] <= link.reg_wdata[gi];
          end
        end
      end else begin : g_none
        assign per_flag_reg[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================================
  // request to the core
  // registered so the core sees a clean level; costs one cycle
  assign core_active = (core_reg[T0IE_BIT] && core_reg[T0IF_BIT])
                    || (core_reg[EXTIE_BIT] && core_reg[EXTIF_BIT])
                    || (core_reg[PORT_CHANGE_IRQ_ENABLE_BIT] && core_reg[PORT_CHANGE_IRQ_FLAG_BIT]);
  // unimplemented enable bits are zero, so they never match
  assign per_active = core_reg[PERIPHERAL_GROUP_ENABLE_BIT] && |(per_flag_reg & per_en_reg);
  assign irq_next = core_reg[GIE_BIT] && (core_active || per_active);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // ==========================================================
  // register reads
  // read data holds until the next read, which the host relies on
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else if (link.reg_rd) begin
      unique case (link.reg_addr)
        CORE_CTRL_ADDR: begin
          rdata_reg <= core_reg;
        end
        PER_EN_ADDR: begin
          rdata_reg <= per_en_reg;
        end
        PER_FLAG_ADDR: begin
          rdata_reg <= per_flag_reg;
        end
        default: begin
          rdata_reg <= '0;
        end
      endcase
    end
  end

  // every access, mapped or not, is acknowledged once
  // so the host never waits on a hole in the map
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= link.reg_wr || link.reg_rd;
    end
  end

  // ==========================================================
  // outputs
  assign link.reg_rdata = rdata_reg;
  assign link.reg_ack = ack_reg;
  assign link.core_irq = irq_reg;
  assign core_ctrl_view = core_reg;
  assign per_en_view = per_en_reg;
  assign per_flag_view = per_flag_reg;

endmodule : ief_device
`default_nettype wire

// File: tb/ief_checker.sv
// concurrent checks on the link between host and device
`timescale 1ns/1ps
`default_nettype none
module ief_checker
  import ief_pkg::*;
(
  // clock and reset
  input wire logic                         clock,
  input wire logic                         reset,
  // link signals
  input wire logic [ief_pkg::IEF_AW-1:0]   reg_addr,
  input wire logic [ief_pkg::IEF_DW-1:0]   reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [ief_pkg::IEF_DW-1:0]   reg_rdata,
  input wire logic                         reg_ack,
  input wire logic                         timer_zero_overflow,
  input wire logic                         external_edge_pin,
  input wire logic [ief_pkg::IEF_PINS-1:0] upper_port_b_pins,
  input wire logic [ief_pkg::IEF_DW-1:0]   per_event,
  input wire logic                         core_irq
);
  import ief_pkg::*;
  logic [7:0] ctrl_reg;
  logic [7:0] pen_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  // ==========================================================
  // shadows: enables change only by writes, so copies are exact
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 8'h00;
    end else if (reg_wr && reg_addr == CORE_CTRL_ADDR) begin
      ctrl_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pen_reg <= 8'h00;
    end else if (reg_wr && reg_addr == PER_EN_ADDR) begin
      pen_reg <= reg_wdata & PER_IMPL_MASK;
    end
  end

  // ==========================================================
  // assertions
  a_ack_after_req: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("link access not acknowledged");
  a_rdata_on_ack: assert property ($changed(reg_rdata) |-> reg_ack && $past(reg_rd))
    else $error("read data moved outside a read");
  a_unimpl_zero: assert property (
    reg_ack && $past(reg_rd) && ($past(reg_addr) == PER_EN_ADDR
    || $past(reg_addr) == PER_FLAG_ADDR) |-> (reg_rdata & ~PER_IMPL_MASK) == 8'h00)
    else $error("unimplemented bits read nonzero");
  a_irq_needs_gie: assert property (core_irq |-> $past(ctrl_reg[GIE_BIT]))
    else $error("request while global enable clear");
  a_periph_needs_group: assert property (
    core_irq && !$past(|ctrl_reg[5:3]) |-> $past(ctrl_reg[PERIPHERAL_GROUP_ENABLE_BIT]) && $past(|pen_reg))
    else $error("peripheral request without group enable");
  a_t0_raises_irq: assert property (
    timer_zero_overflow && ctrl_reg[GIE_BIT] && ctrl_reg[T0IE_BIT] |-> ##2 core_irq)
    else $error("timer zero overflow gave no request");
  a_ext_raises_irq: assert property (
    $rose(external_edge_pin) && ctrl_reg[GIE_BIT] && ctrl_reg[EXTIE_BIT] |-> ##2 core_irq)
    else $error("edge pin gave no request");
  a_change_raises_irq: assert property (
    upper_port_b_pins != $past(upper_port_b_pins) && ctrl_reg[GIE_BIT]
    && ctrl_reg[PORT_CHANGE_IRQ_ENABLE_BIT] |-> ##2 core_irq)
    else $error("port change gave no request");
  a_per_raises_irq: assert property (
    |(per_event & pen_reg) && ctrl_reg[GIE_BIT] && ctrl_reg[PERIPHERAL_GROUP_ENABLE_BIT] |-> ##2 core_irq)
    else $error("peripheral event gave no request");
endmodule : ief_checker
`default_nettype wire

// File: tb/ief_bench.sv
// self-checking bench for the interrupt enable and flag logic
`timescale 1ns/1ps
`default_nettype none
module ief_bench;
  import ief_pkg::*;
  logic        clock;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        irq;
  logic        hresp;
  logic        tzo;
  logic        ext;
  logic [3:0]  pins;
  logic [7:0]  pev;
  logic [7:0]  cview;
  logic [7:0]  eview;
  logic [7:0]  fview;
  int          err_total;
  int          comparisons;

  ief_if ief_if_inst ();
  ief_host ief_host_inst (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .timer_zero_overflow(tzo), .external_edge_pin(ext), .upper_port_b_pins(pins),
    .per_event(pev), .link(ief_if_inst));
  ief_device ief_device_inst (
    .clock(clock), .reset(reset), .link(ief_if_inst), .core_ctrl_view(cview),
    .per_en_view(eview), .per_flag_view(fview));
  ief_checker ief_checker_inst (
    .clock(clock), .reset(reset), .reg_addr(ief_if_inst.reg_addr),
    .reg_wdata(ief_if_inst.reg_wdata), .reg_wr(ief_if_inst.reg_wr),
    .reg_rd(ief_if_inst.reg_rd), .reg_rdata(ief_if_inst.reg_rdata),
    .reg_ack(ief_if_inst.reg_ack), .timer_zero_overflow(ief_if_inst.timer_zero_overflow),
    .external_edge_pin(ief_if_inst.external_edge_pin),
    .upper_port_b_pins(ief_if_inst.upper_port_b_pins),
    .per_event(ief_if_inst.per_event), .core_irq(ief_if_inst.core_irq));

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // single word transfer; waits on hreadyout with no fixed count
  task automatic ahb(input logic wr, input logic [4:0] o, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {27'h0, o};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic hr(input logic [4:0] o, input logic [31:0] e, input string nm);
    logic [31:0] q;
    ahb(1'b0, o, 32'h0, q);
    chk(nm, e, q);
  endtask : hr

  task automatic dacc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [31:0] r;
    ahb(1'b1, HOST_CMD_OFS, {15'h0, wr, a, d}, r);
    do ahb(1'b0, HOST_STAT_OFS, 32'h0, r); while (r[0] !== 1'b0);
    q = r[15:8];
  endtask : dacc

  task automatic dw(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    dacc(1'b1, a, d, q);
  endtask : dw

  task automatic dc(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    dacc(1'b0, a, 8'h00, q);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask : dc

  task automatic ic(input logic e);
    chk("core_irq", {31'h0, e}, {31'h0, ief_if_inst.core_irq});
  endtask : ic

  // 0..7 peripheral bit, 8 timer zero, 9 edge pin, 10 one port pin
  task automatic fire(input int s);
    if (s == 9 && ext === 1'b1) begin
      ext <= 1'b0;
      repeat (3) @(posedge clock);
    end
    case (s)
      8: tzo <= 1'b1;
      9: ext <= 1'b1;
      10: pins <= {pins[2:0], ~pins[3]};
      default: pev <= 8'h01 << s;
    endcase
    @(posedge clock);
    tzo <= 1'b0;
    pev <= 8'h00;
    repeat (5) @(posedge clock);
  endtask : fire

  // ==========================================================
  // scenarios
  task automatic t_regs();
    dc(PER_FLAG_ADDR, 8'h00, "flags after reset");
    dw(PER_EN_ADDR, 8'hff);
    dc(PER_EN_ADDR, 8'h4f, "enable bits");
    chk("enable view", 32'h4f, {24'h0, eview});
    dw(PER_FLAG_ADDR, 8'hff);
    dc(PER_FLAG_ADDR, 8'h4f, "flag bits");
    chk("flag view", 32'h4f, {24'h0, fview});
    dw(PER_EN_ADDR, 8'h00);
    dw(PER_FLAG_ADDR, 8'h00);
    dc(8'h55, 8'h00, "unmapped device read");
  endtask : t_regs

  task automatic t_core(input int s, input logic [7:0] e, input logic [7:0] f);
    dw(CORE_CTRL_ADDR, 8'h80);
    fire(s);
    dc(CORE_CTRL_ADDR, 8'h80 | f, "flag while masked");
    ic(1'b0);
    dw(CORE_CTRL_ADDR, 8'h80 | e | f);
    ic(1'b1);
    dw(CORE_CTRL_ADDR, e | f);
    ic(1'b0);
    dc(CORE_CTRL_ADDR, e | f, "flag held");
    chk("core view", {24'h0, e | f}, {24'h0, cview});
    dw(CORE_CTRL_ADDR, 8'h80 | e);
    ic(1'b0);
    fire(s);
    ic(1'b1);
    dw(CORE_CTRL_ADDR, 8'h00);
  endtask : t_core

  task automatic t_per(input int b);
    logic [7:0] m;
    m = 8'h01 << b;
    dw(PER_EN_ADDR, PER_IMPL_MASK ^ m);
    dw(CORE_CTRL_ADDR, 8'hc0);
    fire(b);
    dc(PER_FLAG_ADDR, m, "peripheral flag");
    ic(1'b0);
    dw(PER_EN_ADDR, m);
    ic(1'b1);
    dw(CORE_CTRL_ADDR, 8'h80);
    ic(1'b0);
    dw(CORE_CTRL_ADDR, 8'hc0);
    dw(PER_FLAG_ADDR, 8'h00);
    ic(1'b0);
    fire(b);
    ic(1'b1);
    dw(CORE_CTRL_ADDR, 8'h00);
    dw(PER_FLAG_ADDR, 8'h00);
  endtask : t_per

  task automatic t_host();
    logic [31:0] q;
    ahb(1'b1, HOST_IRQ_MASK_OFS, 32'h1, q);
    hr(HOST_IRQ_MASK_OFS, 32'h1, "irq mask");
    ahb(1'b0, HOST_IRQ_STAT_OFS, 32'h0, q);
    repeat (3) @(posedge clock);
    chk("irq idle", 32'h0, {31'h0, irq});
    dc(CORE_CTRL_ADDR, 8'h00, "core ctrl");
    chk("irq on done", 32'h1, {31'h0, irq});
    hr(HOST_CMD_OFS, 32'h00001000, "command readback");
    hr(HOST_IRQ_STAT_OFS, 32'h1, "irq status");
    repeat (3) @(posedge clock);
    chk("irq after clear", 32'h0, {31'h0, irq});
    dw(CORE_CTRL_ADDR, 8'ha4);
    hr(HOST_STAT_OFS, 32'h2, "status with request");
    hr(HOST_IRQ_STAT_OFS, 32'h3, "irq status rise");
    chk("hresp", 32'h0, {31'h0, hresp});
    dw(CORE_CTRL_ADDR, 8'h00);
    ahb(1'b1, HOST_IRQ_MASK_OFS, 32'h0, q);
    dw(PER_EN_ADDR, 8'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, 5'h1c, 32'hffffffff, q);
    hr(5'h1c, 32'h0, "unmapped host read");
  endtask : t_host

  // ==========================================================
  // clock, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    tzo = 1'b0;
    ext = 1'b0;
    pins = 4'h0;
    pev = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_regs();
    t_core(8, 8'h01 << T0IE_BIT, 8'h01 << T0IF_BIT);
    t_core(9, 8'h01 << EXTIE_BIT, 8'h01 << EXTIF_BIT);
    t_core(9, 8'h01 << EXTIE_BIT, 8'h01 << EXTIF_BIT);
    t_core(10, 8'h01 << PORT_CHANGE_IRQ_ENABLE_BIT, 8'h01 << PORT_CHANGE_IRQ_FLAG_BIT);
    t_core(10, 8'h01 << PORT_CHANGE_IRQ_ENABLE_BIT, 8'h01 << PORT_CHANGE_IRQ_FLAG_BIT);
    for (int b = 0; b < 7; b++) begin
      if (PER_IMPL_MASK[b]) begin
        t_per(b);
      end
    end
    t_host();
    tally_and_finish();
  end

  // whole run needs roughly a thousand cycles
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
endmodule : ief_bench
`default_nettype wire
